// ==== dv/adcs_core_model.sv ====
module adcs_core_model (
  input wire logic clk, // system clock
  input wire logic sample_en, // sample switch closed
  input wire logic conv_hold, // hold for conversion
  input wire logic [9:0] trial_code, // dac trial code
  input wire logic [2:0] channel_select, // selected input
  input wire logic [49:0] ain, // levels, ten bits a channel, an4..an0
  output logic cmp_in // comparator answer
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held = 10'h000; // charge on the hold capacitor
  logic junk = 1'h0; // meaningless answer outside a conversion
  // capacitor follows the selected channel while the switch is closed
  always @(posedge clk) begin
    junk <= ~junk;
    if (sample_en === 1'h1) begin
      held <= ain[channel_select*10 +: 10];
    end
  end
  // comparator settles at once, high keeps the trial bit
  assign cmp_in = (conv_hold === 1'h1) ? (held >= trial_code) : junk;
endmodule

// ==== dv/tb_adcs_top.sv ====
module tb_adcs_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adcs_pkg::*;
  logic clk, rst_b, ce, psel, penable, pwrite, rc_clk_pin, sleep_req, cmp_in; // drives
  logic [11:0] paddr; // apb address
  logic [31:0] pwdata, prdata, rd; // apb data, last read
  logic pready, pslverr, sample_en, conv_hold, vref_pos_ext, vref_neg_ext, conv_irq_req, er;
  logic [9:0] trial_code; // dac code
  logic [2:0] channel_select; // mux select
  logic [4:0] pin_analog, pin_in; // pin modes, pin levels
  logic [49:0] ain = {10'h3C1, 10'h0FF, 10'h2A5, 10'h17E, 10'h001}; // an4..an0
  logic [7:0] pc [5] = '{8'h00, 8'h04, 8'h06, 8'h07, 8'h0E}; // port codes
  logic [4:0] am [5] = '{5'h1F, 5'h0B, 5'h00, 5'h00, 5'h01}; // analog masks
  int bad_count = 0, cmp_count = 0, hc = 0, last_hc = 0, first_seg = 0, n = 0;

  adcs_top dut (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rc_clk_pin(rc_clk_pin), .sleep_req(sleep_req), .cmp_in(cmp_in),
    .pin_in(pin_in), .sample_en(sample_en), .conv_hold(conv_hold), .trial_code(trial_code),
    .channel_select(channel_select), .pin_analog(pin_analog), .vref_pos_ext(vref_pos_ext),
    .vref_neg_ext(vref_neg_ext), .conv_irq_req(conv_irq_req));
  adcs_core_model core (.clk(clk), .sample_en(sample_en), .conv_hold(conv_hold),
    .trial_code(trial_code), .channel_select(channel_select), .ain(ain), .cmp_in(cmp_in));

  // 100 mhz clock and a slower private oscillator
  always #5 clk = ~clk;
  always #70 rc_clk_pin = ~rc_clk_pin;
  // length of each hold phase in clock cycles
  always @(posedge clk) begin
    if (conv_hold === 1'h1) begin
      hc <= hc + 1;
    end else if (hc != 0) begin
      last_hc <= hc;
      hc <= 0;
    end
  end

  task test_done;
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task to(input string nm);
    bad_count++;
    $display("BAD %s expected answer seen timeout", nm);
    test_done;
  endtask
  task tend(input string nm);
    $display("test %s finished, %0d mismatches so far", nm, bad_count);
  endtask
  task wait_clk(input int k);
    repeat (k) @(posedge clk);
  endtask
  // one apb transfer, request held until pready is sampled high
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k >= 20) to("pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'h1, a, d);
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(1'h0, a, 8'h00);
    chk(nm, e, rd);
  endtask
  // expected pair, high byte on top
  function automatic logic [15:0] res_exp(input logic [2:0] ch, input logic rj);
    logic [9:0] v;
    v = ain[ch*10 +: 10];
    return rj ? {6'h00, v} : {v, 6'h00};
  endfunction
  task res_chk(input logic [2:0] ch, input logic rj);
    logic [15:0] e;
    e = res_exp(ch, rj);
    rdc("res_high", ADDR_RES_HIGH, {24'h000000, e[15:8]});
    rdc("res_low", ADDR_RES_LOW, {24'h000000, e[7:0]});
  endtask
  task hold_chk(input int lo, input int hi);
    chk("hold_cycles", 32'h1, {31'h0, (last_hc >= lo && last_hc <= hi)});
  endtask
  // digital pins read their level, analog pins read low
  function automatic logic [31:0] port_exp(input logic [4:0] m);
    logic [4:0] d;
    d = ~m & 5'h15;
    return {26'h0, d[4], 1'h0, d[3:0]};
  endfunction
  // software sequence: on, acquire, go, poll, rest
  task conv(input logic [1:0] cs, input logic [2:0] ch, input logic slp);
    logic [7:0] c;
    int k;
    c = {cs, ch, 3'h1};
    wr(ADDR_CTL0, c); // on before go
    wait_clk(40); // acquisition after channel change
    wr(ADDR_CTL0, c | 8'h04); // bit period kept legal
    sleep_req <= slp;
    k = 0;
    while (conv_hold !== 1'h1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    if (k >= 100) to("hold");
    first_seg = k;
    k = 0;
    do begin
      xfer(1'h0, ADDR_CTL0, 8'h00);
      k++;
    end while (rd[2] !== 1'h0 && k < 300);
    if (k >= 300) to("done");
    sleep_req <= 1'h0;
    wait_clk(70); // two bit periods before next acquisition
  endtask

  initial begin
    {clk, rst_b, psel, penable, pwrite, rc_clk_pin, sleep_req} = 7'h00;
    ce = 1'h1;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pin_in = 5'h15;
    wait_clk(20);
    rst_b <= 1'h1;
    rdc("ctl0", ADDR_CTL0, 32'h00);
    rdc("ctl1", ADDR_CTL1, 32'h00);
    rdc("res_low", ADDR_RES_LOW, 32'h00);
    chk("pin_analog", 32'h1F, {27'h0, pin_analog});
    wr(ADDR_CTL1, 8'hFF);
    rdc("ctl1_fill", ADDR_CTL1, 32'h8F);
    xfer(1'h0, 12'hFFC, 8'h00);
    chk("unmapped_err", 32'h1, {31'h0, er});
    wr(ADDR_RES_HIGH, 8'hA5);
    rdc("res_high_free", ADDR_RES_HIGH, 32'hA5);
    tend("reset");
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CTL1, pc[i]);
      wait_clk(4);
      chk("pin_analog", {27'h0, am[i]}, {27'h0, pin_analog});
      rdc("port", ADDR_PORT, port_exp(am[i]));
      chk("vrefs", 32'h0, {30'h0, vref_pos_ext, vref_neg_ext});
    end
    wr(ADDR_CTL1, 8'h08);
    wait_clk(4);
    chk("vrefs", 32'h3, {30'h0, vref_pos_ext, vref_neg_ext});
    wr(ADDR_CTL1, 8'h01);
    wait_clk(4);
    chk("vrefs", 32'h2, {30'h0, vref_pos_ext, vref_neg_ext});
    tend("ports");
    wr(ADDR_CTL1, 8'h80);
    wr(ADDR_IEN, 8'h40);
    conv(CS_DIV2, 3'h1, 1'h0);
    res_chk(3'h1, 1'h1);
    hold_chk(23, 25);
    chk("first_seg", 32'h1, {31'h0, (first_seg <= 4)});
    rdc("ctl0_done", ADDR_CTL0, 32'h09);
    xfer(1'h0, ADDR_FLAG, 8'h00);
    chk("flag", 32'h40, rd & 32'h40);
    chk("irq_req", 32'h1, {31'h0, conv_irq_req});
    wr(ADDR_FLAG, 8'h00);
    wait_clk(2);
    chk("irq_req", 32'h0, {31'h0, conv_irq_req});
    tend("div2");
    wr(ADDR_CTL1, 8'h00);
    conv(CS_DIV8, 3'h3, 1'h0);
    res_chk(3'h3, 1'h0);
    hold_chk(95, 97);
    conv(CS_DIV32, 3'h0, 1'h0);
    res_chk(3'h0, 1'h0);
    hold_chk(383, 385);
    tend("dividers");
    wr(ADDR_CTL0, 8'h91);
    wait_clk(40);
    wr(ADDR_CTL0, 8'h95);
    wait_clk(100);
    wr(ADDR_CTL0, 8'h91);
    n = 0;
    while (sample_en !== 1'h1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("abort_wait", 32'h1, {31'h0, (n >= 30 && n <= 70)});
    res_chk(3'h0, 1'h0);
    rdc("ctl0_abort", ADDR_CTL0, 32'h91);
    tend("abort");
    wr(ADDR_CTL0, 8'h95); // go on a divided clock, then sleep
    sleep_req <= 1'h1;
    wait_clk(8);
    sleep_req <= 1'h0;
    rdc("ctl0_sleep", ADDR_CTL0, 32'h91);
    res_chk(3'h0, 1'h0);
    tend("sleep_abort");
    wr(ADDR_CTL1, 8'h80);
    conv(CS_RC, 3'h4, 1'h1);
    res_chk(3'h4, 1'h1);
    hold_chk(150, 190);
    wr(ADDR_CTL0, 8'h00);
    wr(ADDR_CTL0, 8'h05);
    rdc("ctl0_on_go", ADDR_CTL0, 32'h01);
    tend("rc_sleep");
    test_done;
  end
endmodule

// ==== rtl/adcs_pkg.sv ====
package adcs_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 10; // 100 mhz system clock
  localparam int TCY_NS = 40; // one instruction cycle, four oscillator periods
  localparam int TCY_CYC = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // least time, round up
  localparam logic [3:0] TCY_LAST = 4'(TCY_CYC - 1); // last count of the rc start wait
  localparam logic [3:0] CONV_LAST = 4'hB; // twelve bit periods, counted 0..11
  localparam logic [3:0] STEP_FIRST = 4'h1; // first period that resolves a bit
  localparam logic [3:0] STEP_LAST = 4'hA; // last period that resolves a bit
  localparam logic [3:0] WAIT_LAST = 4'h1; // two bit periods, counted 0..1
  localparam int RES_W = 10; // result width
  localparam logic [9:0] SAR_INIT = 10'h200; // first trial code, msb set
  localparam logic [3:0] SAR_MSB = 4'h9; // pointer to the msb
  // register indices and byte addresses
  localparam logic [11:0] IDX_PORT = 12'h005; // port pin read
  localparam logic [11:0] IDX_FLAG = 12'h00C; // flag register
  localparam logic [11:0] IDX_RES_HIGH = 12'h01E; // adc_result_high
  localparam logic [11:0] IDX_CTL0 = 12'h01F; // adc_control_0
  localparam logic [11:0] IDX_IEN = 12'h08C; // irq enable register
  localparam logic [11:0] IDX_RES_LOW = 12'h09E; // adc_result_low
  localparam logic [11:0] IDX_CTL1 = 12'h09F; // adc_control_1
  localparam logic [11:0] ADDR_PORT = IDX_PORT << 2;
  localparam logic [11:0] ADDR_FLAG = IDX_FLAG << 2;
  localparam logic [11:0] ADDR_RES_HIGH = IDX_RES_HIGH << 2;
  localparam logic [11:0] ADDR_CTL0 = IDX_CTL0 << 2;
  localparam logic [11:0] ADDR_IEN = IDX_IEN << 2;
  localparam logic [11:0] ADDR_RES_LOW = IDX_RES_LOW << 2;
  localparam logic [11:0] ADDR_CTL1 = IDX_CTL1 << 2;
  // field positions
  localparam int C0_ON = 0; // converter_on
  localparam int C0_GO = 2; // start/done
  localparam int C0_CHS_LSB = 3; // channel_select 5:3
  localparam int C0_CS_LSB = 6; // conv_clock_select 7:6
  localparam int C1_JUST = 7; // justify_select
  localparam int FLAG_BIT = 6; // conversion_irq_flag / conversion_irq_enable
  // reset values
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00; // all pins analog
  localparam logic [7:0] RES_RST = 8'h00;
  // conversion clock selects and divider masks
  localparam logic [1:0] CS_DIV2 = 2'h0;
  localparam logic [1:0] CS_DIV8 = 2'h1;
  localparam logic [1:0] CS_DIV32 = 2'h2;
  localparam logic [1:0] CS_RC = 2'h3;
  localparam logic [4:0] MASK_DIV2 = 5'h01;
  localparam logic [4:0] MASK_DIV8 = 5'h07;
  localparam logic [4:0] MASK_DIV32 = 5'h1F;

  typedef enum logic [2:0] {ST_OFF, ST_ACQ, ST_SYNC, ST_CONV, ST_WAIT} adcs_state_t;

  // analog pins an4..an0 per port_config_field, 1 = analog input, reference pins 0
  function automatic logic [4:0] adcs_analog_mask(input logic [3:0] pcfg);
    logic [4:0] m;
    m = 5'h1F;
    case (pcfg)
      4'h1, 4'h3, 4'hA: m = 5'h17;
      4'h4: m = 5'h0B;
      4'h5: m = 5'h03;
      4'h6, 4'h7: m = 5'h00;
      4'h8, 4'hB, 4'hC: m = 5'h13;
      4'hD: m = 5'h03;
      4'hE, 4'hF: m = 5'h01;
      default: m = 5'h1F;
    endcase
    return m;
  endfunction

  // external positive reference on an3
  function automatic logic adcs_vref_pos(input logic [3:0] pcfg);
    return pcfg inside {4'h1, 4'h3, 4'h5, 4'h8, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};
  endfunction

  // external negative reference on an2
  function automatic logic adcs_vref_neg(input logic [3:0] pcfg);
    return pcfg inside {4'h8, 4'hB, 4'hC, 4'hD, 4'hF};
  endfunction
endpackage

// ==== rtl/adcs_sar.sv ====
module adcs_sar (
  input wire logic clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic ce, // clock enable
  adcs_sar_if.sar sar // step control and trial code
);
  import adcs_pkg::*;

  logic [3:0] ptr; // bit under trial
  logic [9:0] code; // trial code register
  wire [9:0] bit_sel = 10'h001 << ptr; // current bit
  wire [9:0] bit_low = (ptr != 4'h0) ? (10'h001 << 4'(ptr - 4'h1)) : 10'h000; // next bit
  wire [9:0] next_code = (code & ~bit_sel) | (sar.cmp ? bit_sel : 10'h000) | bit_low;

  // successive approximation: keep or drop the bit, try the next
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      code <= 10'h000;
      ptr <= 4'h0;
    end else if (ce) begin
      if (sar.clear) begin
        code <= SAR_INIT;
        ptr <= SAR_MSB;
      end else if (sar.step) begin
        code <= next_code;
        ptr <= (ptr != 4'h0) ? 4'(ptr - 4'h1) : ptr;
      end
    end
  end

  assign sar.code = code;
endmodule

// ==== rtl/adcs_sar_if.sv ====
interface adcs_sar_if;
  logic clear; // load the first trial code
  logic step; // resolve the current bit
  logic cmp; // comparator answer to the current code
  logic [9:0] code; // trial code, final result after ten steps
  modport ctl (output clear, output step, output cmp, input code);
  modport sar (input clear, input step, input cmp, output code);
endinterface

// ==== rtl/adcs_top.sv ====
// Contract
// - five channels, ten-bit successive approximation result
// - done loads result, clears go, sets flag
// - justify bit picks right or left alignment
// - port field sets pins and references
// - control 1 bits 6-4 read zero
// - conversion lasts twelve bit periods
// - clock select: 2, 8, 32 or rc
// - converting asleep needs the rc clock
// - clearing go aborts, result untouched
// - after abort wait two periods, acquire
// - first segment between one cycle and period
// - analog pins read zero on port
// - unused result bits zero, free when off
// - rc clock waits one instruction cycle
// - reset turns off, aborts, pins analog
//
// Added by the designer: register access over APB.
module adcs_top (
  input wire logic clk, // system clock, 100 mhz
  input wire logic rst_b, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic rc_clk_pin, // private rc oscillator, asynchronous
  input wire logic sleep_req, // device sleeping, asynchronous
  input wire logic cmp_in, // comparator answer to trial_code, same clock
  input wire logic [4:0] pin_in, // pin levels an4..an0
  output logic sample_en, // sample switch closed
  output logic conv_hold, // hold for conversion
  output logic [9:0] trial_code, // dac trial code
  output logic [2:0] channel_select, // channel to the mux
  output logic [4:0] pin_analog, // per-pin analog mode
  output logic vref_pos_ext, // positive reference from an3
  output logic vref_neg_ext, // negative reference from an2
  output logic conv_irq_req // flag gated by enable
);
  import adcs_pkg::*;

  adcs_sar_if sar_bus (); // link to the approximation register

  // registers
  logic [1:0] conv_clock_select; // per-bit clock source
  logic converter_on; // module enable
  logic go; // start/done
  logic justify_select; // 1 right, 0 left
  logic [3:0] port_config_field; // pin configuration
  logic [7:0] adc_result_high; // result high byte
  logic [7:0] adc_result_low; // result low byte
  logic conversion_irq_flag; // done flag
  logic conversion_irq_enable; // done enable
  // synchronisers
  logic rc_s1, rc_s2, rc_s3; // rc oscillator, s3 for edge
  logic sleep_s1, sleep_s2; // sleep level
  logic [4:0] pin_s1, pin_s2; // pins
  // sequencer
  logic [4:0] divcnt; // free-running oscillator divider
  adcs_state_t state, next_state;
  logic [3:0] cnt, next_cnt; // period or cycle count
  logic [31:0] rd_data; // read mux
  logic rd_hit; // mapped address

  // bus decode
  wire acc = psel & penable & pready; // completing access
  wire acc_wr = acc & pwrite;
  wire wr_c0 = acc_wr & (paddr == ADDR_CTL0);
  wire wr_c1 = acc_wr & (paddr == ADDR_CTL1);
  wire wr_rh = acc_wr & (paddr == ADDR_RES_HIGH);
  wire wr_rl = acc_wr & (paddr == ADDR_RES_LOW);
  wire wr_fl = acc_wr & (paddr == ADDR_FLAG);
  wire wr_ie = acc_wr & (paddr == ADDR_IEN);
  wire w_go = pwdata[C0_GO];
  wire w_on = pwdata[C0_ON];

  // conversion clock
  wire rc_rise = rc_s2 & ~rc_s3;
  wire [4:0] div_mask = (conv_clock_select == CS_DIV2) ? MASK_DIV2 :
                        (conv_clock_select == CS_DIV8) ? MASK_DIV8 : MASK_DIV32;
  wire tad_tick = (conv_clock_select == CS_RC) ? rc_rise : ((divcnt & div_mask) == div_mask);

  // sequencing events
  wire busy = (state == ST_SYNC) | (state == ST_CONV);
  wire start_req = wr_c0 & w_go & w_on & converter_on & (state == ST_ACQ);
  wire sw_abort = wr_c0 & ~w_go & busy;
  wire sleep_abort = sleep_s2 & (conv_clock_select != CS_RC) & busy;
  wire abort = sw_abort | sleep_abort;
  wire conv_done = (state == ST_CONV) & tad_tick & (cnt == CONV_LAST) & ~abort;
  wire on_next = wr_c0 ? w_on : converter_on;
  wire sync_ready = (conv_clock_select != CS_RC) | (cnt == TCY_LAST);
  wire [4:0] amask = adcs_analog_mask(port_config_field);
  wire [9:0] res = sar_bus.code;
  wire [7:0] fmt_high = justify_select ? {6'h00, res[9:8]} : res[9:2];
  wire [7:0] fmt_low = justify_select ? res[7:0] : {res[1:0], 6'h00};
  wire [7:0] port_val = {2'h0, pin_s2[4] & ~amask[4], 1'b0, pin_s2[3:0] & ~amask[3:0]};

  // approximation register control
  assign sar_bus.clear = (state == ST_SYNC);
  assign sar_bus.step = (state == ST_CONV) & tad_tick & (cnt >= STEP_FIRST)
                        & (cnt <= STEP_LAST);
  // comparator judges our own registered code, so no sync stage:
  // two stages would leave a two-clock bit period one decision behind
  assign sar_bus.cmp = cmp_in;

  adcs_sar u_sar (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .sar(sar_bus)
  );

  // conversion state machine
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ST_OFF: begin
        if (converter_on) begin
          next_state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (start_req) begin
          next_state = ST_SYNC;
          next_cnt = 4'h0;
        end
      end
      ST_SYNC: begin
        // first segment ends on the next period edge, on rc the first one after one instruction cycle
        if (abort) begin
          next_state = ST_WAIT;
          next_cnt = 4'h0;
        end else if (sync_ready & tad_tick) begin
          next_state = ST_CONV;
          next_cnt = 4'h0;
        end else if (cnt != TCY_LAST) begin
          next_cnt = 4'(cnt + 4'h1);
        end
      end
      ST_CONV: begin
        if (abort | conv_done) begin
          next_state = ST_WAIT;
          next_cnt = 4'h0;
        end else if (tad_tick) begin
          next_cnt = 4'(cnt + 4'h1);
        end
      end
      ST_WAIT: begin
        // two periods before sampling resumes
        if (tad_tick) begin
          if (cnt == WAIT_LAST) begin
            next_state = ST_ACQ;
          end else begin
            next_cnt = 4'(cnt + 4'h1);
          end
        end
      end
      default: next_state = ST_OFF;
    endcase
    if (!on_next) begin
      next_state = ST_OFF;
    end
  end

  // state, divider and synchronisers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_OFF;
      cnt <= 4'h0;
      divcnt <= 5'h00;
      {rc_s1, rc_s2, rc_s3, sleep_s1, sleep_s2} <= 5'h00;
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      divcnt <= 5'(divcnt + 5'h01);
      {rc_s1, rc_s2, rc_s3} <= {rc_clk_pin, rc_s1, rc_s2};
      {sleep_s1, sleep_s2} <= {sleep_req, sleep_s1};
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // control registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      {conv_clock_select, channel_select, go, converter_on} <= {CTL0_RST[7:2], CTL0_RST[0]};
      {justify_select, port_config_field} <= {CTL1_RST[7], CTL1_RST[3:0]};
      conversion_irq_enable <= 1'b0;
    end else if (ce) begin
      if (wr_c0) begin
        conv_clock_select <= pwdata[C0_CS_LSB +: 2];
        channel_select <= pwdata[C0_CHS_LSB +: 3];
        converter_on <= w_on;
      end
      if (start_req) begin
        go <= 1'b1;
      end else if (conv_done | abort | ~on_next | (wr_c0 & ~w_go)) begin
        go <= 1'b0;
      end
      if (wr_c1) begin
        justify_select <= pwdata[C1_JUST];
        port_config_field <= pwdata[3:0];
      end
      if (wr_ie) begin
        conversion_irq_enable <= pwdata[FLAG_BIT];
      end
    end
  end

  // result pair and done flag, completion wins over writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      adc_result_high <= RES_RST;
      adc_result_low <= RES_RST;
      conversion_irq_flag <= 1'b0;
    end else if (ce) begin
      if (conv_done) begin
        adc_result_high <= fmt_high;
        adc_result_low <= fmt_low;
      end else begin
        if (wr_rh) begin
          adc_result_high <= pwdata[7:0];
        end
        if (wr_rl) begin
          adc_result_low <= pwdata[7:0];
        end
      end
      conversion_irq_flag <= conv_done | (wr_fl ? pwdata[FLAG_BIT] : conversion_irq_flag);
    end
  end

  // read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == ADDR_CTL0) begin
      rd_data[7:0] = {conv_clock_select, channel_select, go, 1'b0, converter_on};
    end else if (paddr == ADDR_CTL1) begin
      rd_data[7:0] = {justify_select, 3'h0, port_config_field};
    end else if (paddr == ADDR_RES_HIGH) begin
      rd_data[7:0] = adc_result_high;
    end else if (paddr == ADDR_RES_LOW) begin
      rd_data[7:0] = adc_result_low;
    end else if (paddr == ADDR_FLAG) begin
      rd_data[FLAG_BIT] = conversion_irq_flag;
    end else if (paddr == ADDR_IEN) begin
      rd_data[FLAG_BIT] = conversion_irq_enable;
    end else if (paddr == ADDR_PORT) begin
      rd_data[7:0] = port_val;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // apb answer, ready in the first access cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel & ~penable & ~pready;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= ~rd_hit;
      end
    end
  end

  // analog side outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sample_en <= 1'b0;
      conv_hold <= 1'b0;
      pin_analog <= 5'h1F;
      vref_pos_ext <= 1'b0;
      vref_neg_ext <= 1'b0;
      conv_irq_req <= 1'b0;
    end else if (ce) begin
      sample_en <= (next_state == ST_ACQ) | (next_state == ST_SYNC);
      conv_hold <= (next_state == ST_CONV);
      pin_analog <= amask;
      vref_pos_ext <= adcs_vref_pos(port_config_field);
      vref_neg_ext <= adcs_vref_neg(port_config_field);
      conv_irq_req <= conversion_irq_flag & conversion_irq_enable;
    end
  end

  assign trial_code = sar_bus.code;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [3:0] conv_ticks; // periods seen in conversion
  always_ff @(posedge clk) begin
    if (!rst_b || state != ST_CONV) begin
      conv_ticks <= 4'h0;
    end else if (ce && tad_tick) begin
      conv_ticks <= 4'(conv_ticks + 4'h1);
    end
  end

  property p_done_effects;
    ce && conv_done |=> !go && conversion_irq_flag && state == ST_WAIT;
  endproperty
  a_done_effects: assert property (p_done_effects) else $error("done effects missing");
  property p_twelve;
    ce && conv_done |-> conv_ticks == 4'hB && tad_tick;
  endproperty
  a_twelve: assert property (p_twelve) else $error("conversion not twelve periods");
  property p_right;
    ce && conv_done && justify_select |=> adc_result_high[7:2] == 6'h00;
  endproperty
  a_right: assert property (p_right) else $error("right justify high bits set");
  property p_left;
    ce && conv_done && !justify_select |=> adc_result_low[5:0] == 6'h00;
  endproperty
  a_left: assert property (p_left) else $error("left justify low bits set");
  property p_ctl1_zero;
    ce && psel && !penable && !pwrite && paddr == ADDR_CTL1 |=> prdata[6:4] == 3'h0;
  endproperty
  a_ctl1_zero: assert property (p_ctl1_zero) else $error("reserved bits read set");
  property p_div2;
    ce && tad_tick && conv_clock_select == CS_DIV2 && !wr_c0 |=> !tad_tick;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two tick too fast");
  property p_abort;
    ce && state == ST_CONV && sw_abort |=> $stable(adc_result_high) && !go;
  endproperty
  a_abort: assert property (p_abort) else $error("abort updated result");
  property p_wait2;
    ce && state == ST_WAIT && tad_tick && cnt == WAIT_LAST && on_next |=> state == ST_ACQ;
  endproperty
  a_wait2: assert property (p_wait2) else $error("acquisition not resumed");
  property p_port;
    ce && psel && !penable && !pwrite && paddr == ADDR_PORT && amask[0] |=> !prdata[0];
  endproperty
  a_port: assert property (p_port) else $error("analog pin read nonzero");
  property p_first_seg;
    ce && start_req && conv_clock_select == CS_DIV8 && !sleep_abort
      |=> (state == ST_SYNC)[*1] ##[0:8] state != ST_SYNC;
  endproperty
  a_first_seg: assert property (p_first_seg) else $error("first segment too long");

  c_done: cover property (ce && conv_done);
  c_abort: cover property (ce && sw_abort && state == ST_CONV);
  c_rc_conv: cover property (ce && conv_done && conv_clock_select == CS_RC);
  c_sleep_abort: cover property (ce && sleep_abort);
endmodule
